/* File: hw/bulk_out_irq_pkg.sv */
// Constants for the bulk OUT and alternate-setting event status block
package bulk_out_irq_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 8;
	localparam int CH_FLAGS = 4;
	localparam int CHANNELS = 2;

	localparam logic [ADDR_W-1:0] BULK_OUT_EVENT_STATUS_ADDR   = 20'hF0553;
	localparam logic [ADDR_W-1:0] ALT_SETTING_EVENT_STATUS_ADDR = 20'hF0554;
	localparam logic [ADDR_W-1:0] BULK_OUT_EVENT_MASK_ADDR     = 20'hF055A;
	localparam logic [ADDR_W-1:0] ALT_SETTING_EVENT_MASK_ADDR  = 20'hF055B;
	localparam logic [ADDR_W-1:0] BULK_OUT_EVENT_CLEAR_ADDR    = 20'hF055F;
	localparam logic [ADDR_W-1:0] ALT_SETTING_EVENT_CLEAR_ADDR = 20'hF0560;

	// Flag positions inside one channel nibble
	localparam int FULL_BIT = 3;
	localparam int NULL_BIT = 2;
	localparam int NAK_BIT  = 1;
	localparam int DONE_BIT = 0;
	// Alternate-setting done flag position
	localparam int ALT_DONE_BIT = 5;

	localparam logic [DATA_W-1:0] STATUS_RESET   = 8'h00;
	localparam logic [DATA_W-1:0] MASK_RESET     = 8'h00;
	localparam logic [DATA_W-1:0] CLEAR_READ_VAL = 8'hFF;
	localparam logic [DATA_W-1:0] UNMAPPED_READ  = 8'h00;
	localparam logic [DATA_W-1:0] ALT_ONLY       = 8'h20;
endpackage

/* File: hw/bulk_out_channel_flags.sv */
// Event flags of one bulk OUT channel
`timescale 1ns/1ns
module bulk_out_channel_flags (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_supported,
	input  wire logic       i_rx_done,
	input  wire logic       i_rx_zero_len,
	input  wire logic       i_out_nak,
	input  wire logic       i_cpu_has_data,
	input  wire logic       i_sie_has_data,
	input  wire logic       i_fifo_toggle,
	input  wire logic       i_cpu_read_empty,
	input  wire logic       i_clear_wr,
	input  wire logic [3:0] i_clear_bits,
	output logic      [3:0] o_flags,
	output logic            o_receive_irq_line,
	output logic            o_endpoint_status_set
);
	logic [3:0] flags;
	logic       null_pending;
	logic       hold;
	logic       eps_set;
	logic [3:0] next_flags;
	logic       next_null_pending;
	logic       next_hold;
	logic       next_eps_set;
	logic [3:0] set_v;
	logic [3:0] clr_v;

	always_comb begin
		set_v = '0;
		clr_v = '0;
		set_v[bulk_out_irq_pkg::FULL_BIT] = i_cpu_has_data & i_sie_has_data;
		set_v[bulk_out_irq_pkg::NULL_BIT] = (i_rx_done & i_rx_zero_len & ~i_cpu_has_data)
			| (null_pending & i_cpu_read_empty);
		set_v[bulk_out_irq_pkg::NAK_BIT] = i_out_nak;
		set_v[bulk_out_irq_pkg::DONE_BIT] = i_rx_done & ~i_rx_zero_len;
		set_v = set_v & {4{i_supported}};
		if (i_clear_wr) begin
			clr_v = ~i_clear_bits;
		end
		clr_v[bulk_out_irq_pkg::FULL_BIT] = clr_v[bulk_out_irq_pkg::FULL_BIT] | i_fifo_toggle;
		clr_v[bulk_out_irq_pkg::DONE_BIT] = clr_v[bulk_out_irq_pkg::DONE_BIT] | i_cpu_read_empty;
		next_flags = ((flags & ~clr_v) | set_v) & {4{i_supported}};
		next_null_pending = null_pending;
		if (i_rx_done & i_rx_zero_len & i_cpu_has_data & i_supported) begin
			next_null_pending = 1'b1;
		end else if (i_cpu_read_empty | ~i_supported) begin
			next_null_pending = 1'b0;
		end
		next_hold = hold;
		if (flags[bulk_out_irq_pkg::DONE_BIT] & i_cpu_read_empty & i_sie_has_data & i_supported) begin
			next_hold = 1'b1;
		end else if (~i_sie_has_data | set_v[bulk_out_irq_pkg::DONE_BIT] | ~i_supported) begin
			next_hold = 1'b0;
		end
		next_eps_set = set_v[bulk_out_irq_pkg::DONE_BIT];
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			flags        <= 4'h0;
			null_pending <= 1'b0;
			hold         <= 1'b0;
			eps_set      <= 1'b0;
		end else begin
			flags        <= next_flags;
			null_pending <= next_null_pending;
			hold         <= next_hold;
			eps_set      <= next_eps_set;
		end
	end

	assign o_flags               = flags;
	assign o_receive_irq_line    = flags[bulk_out_irq_pkg::DONE_BIT] | hold;
	assign o_endpoint_status_set = eps_set;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);

	a_full_sets: assert property (i_supported && i_cpu_has_data && i_sie_has_data |=> o_flags[3])
		else $error("both-full flag not set");
	a_full_toggle: assert property (i_fifo_toggle && !(i_cpu_has_data && i_sie_has_data) |=> !o_flags[3])
		else $error("both-full flag survived toggle");
	a_null_now: assert property (i_supported && i_rx_done && i_rx_zero_len && !i_cpu_has_data |=> o_flags[2])
		else $error("null flag not set at once");
	a_null_later: assert property (i_supported && i_rx_done && i_rx_zero_len && i_cpu_has_data && !i_cpu_read_empty
		##1 i_supported && i_cpu_read_empty |=> o_flags[2])
		else $error("deferred null flag not set");
	a_nak_sets: assert property (i_supported && i_out_nak |=> o_flags[1])
		else $error("NAK flag not set");
	a_done_pair: assert property (i_supported && i_rx_done && !i_rx_zero_len |=> o_flags[0] && o_endpoint_status_set)
		else $error("done flag and endpoint status not set together");
	a_done_not_null: assert property (!o_flags[0] && i_rx_done && i_rx_zero_len |=> !o_flags[0])
		else $error("done flag set by null packet");
	a_done_clears: assert property (i_cpu_read_empty && !i_rx_done |=> !o_flags[0])
		else $error("done flag not cleared by read");
	a_hold_line: assert property (i_supported && o_flags[0] && i_cpu_read_empty && i_sie_has_data && !i_rx_done
		|=> o_receive_irq_line [*1] ##0 !o_flags[0])
		else $error("receive line dropped with data waiting");
	a_unsupported: assert property (!i_supported |=> o_flags == 4'h0)
		else $error("flag of unsupported endpoint set");
endmodule // bulk_out_channel_flags

/* File: hw/bulk_out_irq_status.sv */
// Bulk OUT and alternate-setting event status registers with controller interrupt
// Contract
// - Any unmasked flag set in either status register raises the controller interrupt line.
// - Status registers are read-only 8-bit; writes never alter them.
// - Writing 0 to a clear bit zeroes its status bit; 1 leaves it.
// - Flags of endpoints not supported by configuration are invalid and read zero.
// - Channel 1 serves endpoint 2 in bits 3-0; channel 2 endpoint 4 in 7-4.
// - Both-full flag sets while both FIFOs hold data, clears on toggle.
// - Null flag sets at once on zero-length packet with empty FIFO.
// - With CPU FIFO holding data, null flag waits until that FIFO is read.
// - NAK flag sets when an OUT token gets a NAK answer.
// - Done flag sets when good data received and the FIFOs toggled.
// - Endpoint status bits set in the same cycle as the done flag.
// - Done flag never sets for a zero-length packet.
// - Done flag clears when firmware reads bring the length count to zero.
// - Request stays active when done clears with SIE FIFO still holding data.
// - Alternate-setting done flag, bit 5, sets on automatic SET_INTERFACE handling.
// - Both registers reset to 00H; other bits of the second read zero.
// - A mask bit at 1 keeps its source off the interrupt; reset unmasked.
`timescale 1ns/1ns
module bulk_out_irq_status #(
	parameter int CHANNELS = bulk_out_irq_pkg::CHANNELS
) (
	input  wire logic                                  i_ref_clk,
	input  wire logic                                  i_rst_b,
	input  wire logic [bulk_out_irq_pkg::ADDR_W-1:0]   i_addr,
	input  wire logic                                  i_wr,
	input  wire logic                                  i_rd,
	input  wire logic [bulk_out_irq_pkg::DATA_W-1:0]   i_wdata,
	output logic      [bulk_out_irq_pkg::DATA_W-1:0]   o_rdata,
	input  wire logic [CHANNELS-1:0]                   i_ep_supported,
	input  wire logic [CHANNELS-1:0]                   i_rx_done,
	input  wire logic [CHANNELS-1:0]                   i_rx_zero_len,
	input  wire logic [CHANNELS-1:0]                   i_out_nak,
	input  wire logic [CHANNELS-1:0]                   i_cpu_has_data,
	input  wire logic [CHANNELS-1:0]                   i_sie_has_data,
	input  wire logic [CHANNELS-1:0]                   i_fifo_toggle,
	input  wire logic [CHANNELS-1:0]                   i_cpu_read_empty,
	input  wire logic                                  i_set_interface_done,
	output logic                                       o_controller_irq,
	output logic                                       o_receive_irq_line,
	output logic      [CHANNELS-1:0]                   o_endpoint_status_set
);
	if (CHANNELS != bulk_out_irq_pkg::CHANNELS) begin : g_bad_channels
		$error("CHANNELS must be 2 to fit one 8-bit status register");
	end

	logic [bulk_out_irq_pkg::DATA_W-1:0] bulk_out_event_status;
	logic [bulk_out_irq_pkg::DATA_W-1:0] alt_setting_event_status;
	logic [bulk_out_irq_pkg::DATA_W-1:0] bulk_out_event_mask;
	logic [bulk_out_irq_pkg::DATA_W-1:0] alt_setting_event_mask;
	logic                                alt_setting_done_flag;
	logic [bulk_out_irq_pkg::DATA_W-1:0] rdata;
	logic                                next_alt_setting_done_flag;
	logic [bulk_out_irq_pkg::DATA_W-1:0] next_bulk_out_event_mask;
	logic [bulk_out_irq_pkg::DATA_W-1:0] next_alt_setting_event_mask;
	logic [bulk_out_irq_pkg::DATA_W-1:0] next_rdata;
	logic [CHANNELS-1:0]                 ch_line;
	logic [CHANNELS-1:0]                 ch_hold;
	logic                                clear3_wr;
	logic                                clear4_wr;

	function automatic logic hit(input logic [bulk_out_irq_pkg::ADDR_W-1:0] a,
		input logic [bulk_out_irq_pkg::ADDR_W-1:0] reg_addr);
		hit = (a == reg_addr);
	endfunction

	assign clear3_wr = i_wr & hit(i_addr, bulk_out_irq_pkg::BULK_OUT_EVENT_CLEAR_ADDR);
	assign clear4_wr = i_wr & hit(i_addr, bulk_out_irq_pkg::ALT_SETTING_EVENT_CLEAR_ADDR);

	for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
		logic [3:0] flags;
		bulk_out_channel_flags u_flags (
			.i_ref_clk             (i_ref_clk),
			.i_rst_b               (i_rst_b),
			.i_supported           (i_ep_supported[c]),
			.i_rx_done             (i_rx_done[c]),
			.i_rx_zero_len         (i_rx_zero_len[c]),
			.i_out_nak             (i_out_nak[c]),
			.i_cpu_has_data        (i_cpu_has_data[c]),
			.i_sie_has_data        (i_sie_has_data[c]),
			.i_fifo_toggle         (i_fifo_toggle[c]),
			.i_cpu_read_empty      (i_cpu_read_empty[c]),
			.i_clear_wr            (clear3_wr),
			.i_clear_bits          (i_wdata[c*4 +: 4]),
			.o_flags               (flags),
			.o_receive_irq_line    (ch_line[c]),
			.o_endpoint_status_set (o_endpoint_status_set[c])
		);
		assign bulk_out_event_status[c*4 +: 4] = flags;
		// held line, gated by done mask
		assign ch_hold[c] = ch_line[c] & ~bulk_out_event_mask[c*4 + bulk_out_irq_pkg::DONE_BIT];
	end

	assign alt_setting_event_status = {2'b00, alt_setting_done_flag, 5'b00000};

	always_comb begin
		next_alt_setting_done_flag  = alt_setting_done_flag;
		next_bulk_out_event_mask    = bulk_out_event_mask;
		next_alt_setting_event_mask = alt_setting_event_mask;
		next_rdata                  = rdata;
		if (clear4_wr && !i_wdata[bulk_out_irq_pkg::ALT_DONE_BIT]) begin
			next_alt_setting_done_flag = 1'b0;
		end
		if (i_set_interface_done) begin
			next_alt_setting_done_flag = 1'b1;
		end
		if (i_wr && hit(i_addr, bulk_out_irq_pkg::BULK_OUT_EVENT_MASK_ADDR)) begin
			next_bulk_out_event_mask = i_wdata;
		end
		if (i_wr && hit(i_addr, bulk_out_irq_pkg::ALT_SETTING_EVENT_MASK_ADDR)) begin
			next_alt_setting_event_mask = i_wdata & bulk_out_irq_pkg::ALT_ONLY;
		end
		if (i_rd) begin
			unique case (i_addr)
				bulk_out_irq_pkg::BULK_OUT_EVENT_STATUS_ADDR:    next_rdata = bulk_out_event_status;
				bulk_out_irq_pkg::ALT_SETTING_EVENT_STATUS_ADDR: next_rdata = alt_setting_event_status;
				bulk_out_irq_pkg::BULK_OUT_EVENT_MASK_ADDR:      next_rdata = bulk_out_event_mask;
				bulk_out_irq_pkg::ALT_SETTING_EVENT_MASK_ADDR:   next_rdata = alt_setting_event_mask;
				bulk_out_irq_pkg::BULK_OUT_EVENT_CLEAR_ADDR:     next_rdata = bulk_out_irq_pkg::CLEAR_READ_VAL;
				bulk_out_irq_pkg::ALT_SETTING_EVENT_CLEAR_ADDR:  next_rdata = bulk_out_irq_pkg::CLEAR_READ_VAL;
				default:                                         next_rdata = bulk_out_irq_pkg::UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			alt_setting_done_flag  <= 1'b0;
			bulk_out_event_mask    <= bulk_out_irq_pkg::MASK_RESET;
			alt_setting_event_mask <= bulk_out_irq_pkg::MASK_RESET;
			rdata                  <= bulk_out_irq_pkg::STATUS_RESET;
		end else begin
			alt_setting_done_flag  <= next_alt_setting_done_flag;
			bulk_out_event_mask    <= next_bulk_out_event_mask;
			alt_setting_event_mask <= next_alt_setting_event_mask;
			rdata                  <= next_rdata;
		end
	end

	assign o_rdata            = rdata;
	assign o_receive_irq_line = |ch_line;
	assign o_controller_irq = (|(bulk_out_event_status & ~bulk_out_event_mask))
		| (|(alt_setting_event_status & ~alt_setting_event_mask))
		| (|ch_hold);

	logic quiet;
	assign quiet = ~|{i_rx_done, i_out_nak, i_fifo_toggle, i_cpu_read_empty, i_cpu_has_data & i_sie_has_data}
		& (&i_ep_supported);

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);

	a_irq_on_change: assert property ($rose(bulk_out_event_status[0]) && !bulk_out_event_mask[0]
		|-> o_controller_irq)
		else $error("status change did not raise interrupt");
	a_irq_level: assert property ((bulk_out_event_status & ~bulk_out_event_mask) != 8'h00 && $stable(bulk_out_event_status)
		|-> o_controller_irq)
		else $error("interrupt dropped while unmasked flag set");
	a_status_write_ro: assert property (quiet && i_wr && hit(i_addr, bulk_out_irq_pkg::BULK_OUT_EVENT_STATUS_ADDR)
		|=> bulk_out_event_status == $past(bulk_out_event_status))
		else $error("write altered read-only status");
	a_status_readback: assert property (i_rd && hit(i_addr, bulk_out_irq_pkg::BULK_OUT_EVENT_STATUS_ADDR)
		|=> o_rdata == $past(bulk_out_event_status))
		else $error("status read returned wrong value");
	a_clear_by_zero: assert property (quiet && clear3_wr
		|=> bulk_out_event_status == ($past(bulk_out_event_status) & $past(i_wdata)))
		else $error("clear register did not act per bit");
	a_ch2_nak_bit: assert property (i_ep_supported[1] && i_out_nak[1] |=> bulk_out_event_status[5])
		else $error("channel 2 NAK not in bit 5");
	a_alt_set_wins: assert property (i_set_interface_done |=> alt_setting_event_status == 8'h20)
		else $error("alternate-setting flag not set");
	a_alt_read_zero: assert property (i_rd && hit(i_addr, bulk_out_irq_pkg::ALT_SETTING_EVENT_STATUS_ADDR)
		|=> (o_rdata & 8'hDF) == 8'h00)
		else $error("reserved status bits read nonzero");
	a_masked_quiet: assert property (bulk_out_event_mask == 8'hFF && alt_setting_event_mask == 8'h20
		|-> !o_controller_irq)
		else $error("masked source raised interrupt");
	a_reset_clear: assert property (@(posedge i_ref_clk) disable iff (1'b0)
		!i_rst_b |=> bulk_out_event_status == 8'h00
		&& alt_setting_event_status == 8'h00 && bulk_out_event_mask == 8'h00)
		else $error("registers not at reset value");
	a_invalid_ep: assert property (!i_ep_supported[0] |=> bulk_out_event_status[3:0] == 4'h0)
		else $error("unsupported endpoint flags visible");

	a_irq_any_flag: assert property (
		(bulk_out_event_status & ~bulk_out_event_mask) != 8'h00 |-> o_controller_irq)
		else $error("unmasked bulk flag without interrupt");

	a_irq_alt_flag: assert property (
		(alt_setting_event_status & ~alt_setting_event_mask) != 8'h00 |-> o_controller_irq)
		else $error("unmasked alternate-setting flag without interrupt");

	a_irq_idle: assert property (
		(bulk_out_event_status & ~bulk_out_event_mask) == 8'h00 && !o_receive_irq_line
		&& (alt_setting_event_status & ~alt_setting_event_mask) == 8'h00 |-> !o_controller_irq)
		else $error("interrupt with no unmasked source");

	a_irq_alt_rise: assert property (
		$rose(alt_setting_done_flag) && !alt_setting_event_mask[bulk_out_irq_pkg::ALT_DONE_BIT] |-> o_controller_irq)
		else $error("alternate-setting change did not raise interrupt");

	a_alt_write_ro: assert property (
		i_wr && hit(i_addr, bulk_out_irq_pkg::ALT_SETTING_EVENT_STATUS_ADDR) && !i_set_interface_done
		|=> alt_setting_event_status == $past(alt_setting_event_status))
		else $error("write altered read-only alternate-setting status");

	a_alt_readback: assert property (
		i_rd && hit(i_addr, bulk_out_irq_pkg::ALT_SETTING_EVENT_STATUS_ADDR)
		|=> o_rdata == $past(alt_setting_event_status))
		else $error("alternate-setting read returned wrong value");

	a_rdata_holds: assert property (
		!i_rd |=> o_rdata == $past(o_rdata))
		else $error("read data changed without a read");

	a_alt_clear_zero: assert property (
		clear4_wr && !i_wdata[bulk_out_irq_pkg::ALT_DONE_BIT] && !i_set_interface_done |=> !alt_setting_done_flag)
		else $error("zero clear bit left alternate-setting flag");

	a_alt_clear_one: assert property (
		clear4_wr && i_wdata[bulk_out_irq_pkg::ALT_DONE_BIT] && alt_setting_done_flag |=> alt_setting_done_flag)
		else $error("one clear bit dropped alternate-setting flag");

	a_clear_reads_ff: assert property (
		i_rd && (hit(i_addr, bulk_out_irq_pkg::BULK_OUT_EVENT_CLEAR_ADDR)
		|| hit(i_addr, bulk_out_irq_pkg::ALT_SETTING_EVENT_CLEAR_ADDR)) |=> o_rdata == 8'hFF)
		else $error("clear register read not FF");

	a_mask_write: assert property (
		i_wr && hit(i_addr, bulk_out_irq_pkg::BULK_OUT_EVENT_MASK_ADDR) |=> bulk_out_event_mask == $past(i_wdata))
		else $error("mask write not taken");

	a_mask_read: assert property (
		i_rd && hit(i_addr, bulk_out_irq_pkg::BULK_OUT_EVENT_MASK_ADDR) |=> o_rdata == $past(bulk_out_event_mask))
		else $error("mask read returned wrong value");

	a_alt_mask_bits: assert property (
		(alt_setting_event_mask & ~bulk_out_irq_pkg::ALT_ONLY) == 8'h00)
		else $error("alternate-setting mask holds reserved bits");

	a_ch1_nak_bit: assert property (
		i_ep_supported[0] && i_out_nak[0] |=> bulk_out_event_status[1])
		else $error("channel 1 NAK not in bit 1");

	a_ch2_null_bit: assert property (
		i_ep_supported[1] && i_rx_done[1] && i_rx_zero_len[1] && !i_cpu_has_data[1] |=> bulk_out_event_status[6])
		else $error("channel 2 null not in bit 6");

	a_ch2_done_bit: assert property (
		i_ep_supported[1] && i_rx_done[1] && !i_rx_zero_len[1]
		|=> bulk_out_event_status[4] && o_endpoint_status_set[1])
		else $error("channel 2 done not in bit 4");

	a_ch2_full_bit: assert property (
		i_ep_supported[1] && i_cpu_has_data[1] && i_sie_has_data[1] |=> bulk_out_event_status[7])
		else $error("channel 2 full not in bit 7");

	a_ch2_toggle: assert property (
		i_fifo_toggle[1] && !(i_cpu_has_data[1] && i_sie_has_data[1]) |=> !bulk_out_event_status[7])
		else $error("channel 2 full flag survived toggle");

	a_ch2_read_clears: assert property (
		i_cpu_read_empty[1] && !i_rx_done[1] |=> !bulk_out_event_status[4])
		else $error("channel 2 done flag not cleared by read");

	a_invalid_ep2: assert property (
		!i_ep_supported[1] |=> bulk_out_event_status[7:4] == 4'h0)
		else $error("unsupported channel 2 flags visible");

	a_recv_line_done: assert property (
		bulk_out_event_status[0] || bulk_out_event_status[4] |-> o_receive_irq_line)
		else $error("receive line low with done flag set");

	a_hold_irq: assert property (
		o_receive_irq_line && !bulk_out_event_mask[0] && !bulk_out_event_mask[4] |-> o_controller_irq)
		else $error("interrupt dropped while receive line held");

	a_eps_ch1: assert property (
		o_endpoint_status_set[0] |-> bulk_out_event_status[0])
		else $error("channel 1 endpoint status without done flag");

	a_eps_ch2: assert property (
		o_endpoint_status_set[1] |-> bulk_out_event_status[4])
		else $error("channel 2 endpoint status without done flag");

	a_alt_reserved: assert property (
		(alt_setting_event_status & ~bulk_out_irq_pkg::ALT_ONLY) == 8'h00)
		else $error("reserved alternate-setting bits set");

	a_alt_sticky: assert property (
		alt_setting_done_flag && !clear4_wr |=> alt_setting_done_flag)
		else $error("alternate-setting flag dropped without clear");

	a_irq_reset_low: assert property (disable iff (1'b0)
		!i_rst_b |=> !o_controller_irq && !o_receive_irq_line)
		else $error("interrupt lines active after reset");

	c_rx_done_irq: cover property (i_rx_done[0] && !i_rx_zero_len[0] ##1 o_controller_irq);
	c_null_deferred: cover property (i_rx_done[1] && i_rx_zero_len[1] && i_cpu_has_data[1]
		##[1:20] bulk_out_event_status[6]);
	c_alt_clear: cover property (alt_setting_done_flag ##1 clear4_wr ##1 !alt_setting_done_flag);
	c_hold_line: cover property (o_receive_irq_line && bulk_out_event_status[0] ##1
		o_receive_irq_line && !bulk_out_event_status[0]);
	c_alt_masked: cover property (alt_setting_done_flag && alt_setting_event_mask[5] && !o_controller_irq);
endmodule // bulk_out_irq_status

/* File: dv/sie_event_model.sv */
// Event source standing in for the serial interface engine and the bulk OUT FIFOs
`timescale 1ns/1ns
module sie_event_model (
	input  wire logic       i_ref_clk,
	output logic      [1:0] o_supported,
	output logic      [1:0] o_rx_done,
	output logic      [1:0] o_zero_len,
	output logic      [1:0] o_out_nak,
	output logic      [1:0] o_cpu_has_data,
	output logic      [1:0] o_sie_has_data,
	output logic      [1:0] o_fifo_toggle,
	output logic      [1:0] o_read_empty,
	output logic            o_set_if_done
);
	initial begin
		o_supported = 2'h3;
		{o_rx_done, o_zero_len, o_out_nak, o_cpu_has_data} = 8'h00;
		{o_sie_has_data, o_fifo_toggle, o_read_empty} = 6'h00;
		o_set_if_done = 1'b0;
	end
	// One-cycle strobe: 0 packet, 1 NAK, 2 toggle, 3 CPU FIFO read out, 4 set-interface
	task automatic strobe(input int kind, input int ch);
		@(posedge i_ref_clk);
		#1;
		case (kind)
			0: o_rx_done[ch] = 1'b1;
			1: o_out_nak[ch] = 1'b1;
			2: o_fifo_toggle[ch] = 1'b1;
			3: o_read_empty[ch] = 1'b1;
			default: o_set_if_done = 1'b1;
		endcase
		@(posedge i_ref_clk);
		#1;
		{o_rx_done, o_out_nak, o_fifo_toggle, o_read_empty} = 8'h00;
		o_set_if_done = 1'b0;
	endtask
	// Zero-length packet into a loaded CPU FIFO, that FIFO read out on the very next cycle
	task automatic null_then_drain(input int ch);
		@(posedge i_ref_clk);
		#1;
		{o_rx_done[ch], o_zero_len[ch], o_cpu_has_data[ch]} = 3'b111;
		@(posedge i_ref_clk);
		#1;
		{o_rx_done[ch], o_zero_len[ch], o_cpu_has_data[ch], o_read_empty[ch]} = 4'b0001;
		@(posedge i_ref_clk);
		#1;
		o_read_empty[ch] = 1'b0;
	endtask
endmodule // sie_event_model

/* File: dv/testbench.sv */
// Self-checking testbench for the bulk OUT and alternate-setting status block
`timescale 1ns/1ns
module testbench;
	localparam logic [19:0] ST3 = bulk_out_irq_pkg::BULK_OUT_EVENT_STATUS_ADDR;
	localparam logic [19:0] ST4 = bulk_out_irq_pkg::ALT_SETTING_EVENT_STATUS_ADDR;
	localparam logic [19:0] MK3 = bulk_out_irq_pkg::BULK_OUT_EVENT_MASK_ADDR;
	localparam logic [19:0] MK4 = bulk_out_irq_pkg::ALT_SETTING_EVENT_MASK_ADDR;
	localparam logic [19:0] CL3 = bulk_out_irq_pkg::BULK_OUT_EVENT_CLEAR_ADDR;
	localparam logic [19:0] CL4 = bulk_out_irq_pkg::ALT_SETTING_EVENT_CLEAR_ADDR;
	logic        i_ref_clk, i_rst_b, i_wr, i_rd, o_controller_irq, o_receive_irq_line, set_if;
	logic [19:0] i_addr;
	logic [7:0]  i_wdata, o_rdata;
	logic [1:0]  sup, rx, zl, nak, cpu, sie, tgl, emp, o_endpoint_status_set;
	int          fail_count = 0;
	int          checks = 0;

	sie_event_model u_sie_event_model (.i_ref_clk(i_ref_clk), .o_supported(sup), .o_rx_done(rx),
		.o_zero_len(zl), .o_out_nak(nak), .o_cpu_has_data(cpu), .o_sie_has_data(sie),
		.o_fifo_toggle(tgl), .o_read_empty(emp), .o_set_if_done(set_if));
	bulk_out_irq_status u_bulk_out_irq_status (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
		.i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_ep_supported(sup),
		.i_rx_done(rx), .i_rx_zero_len(zl), .i_out_nak(nak), .i_cpu_has_data(cpu), .i_sie_has_data(sie),
		.i_fifo_toggle(tgl), .i_cpu_read_empty(emp), .i_set_interface_done(set_if),
		.o_controller_irq(o_controller_irq), .o_receive_irq_line(o_receive_irq_line),
		.o_endpoint_status_set(o_endpoint_status_set));

	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	task automatic end_sim();
		if (fail_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask

	task automatic reg_write(input logic [19:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		#1;
		{i_addr, i_wdata, i_wr} = {a, d, 1'b1};
		tick(1);
		i_wr = 1'b0;
	endtask

	task automatic reg_read(input logic [19:0] a, input logic [7:0] exp);
		@(posedge i_ref_clk);
		#1;
		{i_addr, i_rd} = {a, 1'b1};
		tick(1);
		i_rd = 1'b0;
		chk(o_rdata, exp);
	endtask

	task automatic ev(input int kind, input int ch);
		u_sie_event_model.strobe(kind, ch);
	endtask

	task automatic t_reset();
		reg_read(ST3, 8'h00);
		reg_read(ST4, 8'h00);
		reg_read(CL3, 8'hFF);
		reg_read(CL4, 8'hFF);
		reg_read(20'h00001, 8'h00);
		reg_read(MK3, 8'h00);
		chk(o_controller_irq, 1'b0);
	endtask

	task automatic t_done();
		ev(0, 0);
		chk(o_endpoint_status_set, 2'h1);
		chk(o_controller_irq, 1'b1);
		tick(1);
		chk(o_endpoint_status_set, 2'h0);
		reg_write(ST3, 8'h00);
		reg_read(ST3, 8'h01);
		ev(3, 0);
		reg_read(ST3, 8'h00);
		chk(o_controller_irq, 1'b0);
	endtask

	task automatic t_null_nak();
		u_sie_event_model.o_zero_len[0] = 1'b1;
		ev(0, 0);
		chk(o_endpoint_status_set, 2'h0);
		u_sie_event_model.o_zero_len[0] = 1'b0;
		ev(1, 0);
		reg_read(ST3, 8'h06);
		reg_write(CL3, 8'hFB);
		reg_read(ST3, 8'h02);
		reg_write(CL3, 8'hFD);
		reg_read(ST3, 8'h00);
	endtask

	task automatic t_defer();
		{u_sie_event_model.o_cpu_has_data[1], u_sie_event_model.o_zero_len[1]} = 2'h3;
		ev(0, 1);
		reg_read(ST3, 8'h00);
		{u_sie_event_model.o_cpu_has_data[1], u_sie_event_model.o_zero_len[1]} = 2'h0;
		ev(3, 1);
		reg_read(ST3, 8'h40);
		reg_write(CL3, 8'hBF);
		u_sie_event_model.null_then_drain(1);
		reg_read(ST3, 8'h40);
		reg_write(CL3, 8'hBF);
		reg_read(ST3, 8'h00);
	endtask

	task automatic t_full();
		{u_sie_event_model.o_cpu_has_data[1], u_sie_event_model.o_sie_has_data[1]} = 2'h3;
		tick(2);
		reg_read(ST3, 8'h80);
		u_sie_event_model.o_sie_has_data[1] = 1'b0;
		ev(2, 1);
		reg_read(ST3, 8'h00);
		ev(0, 1);
		chk(o_endpoint_status_set, 2'h2);
		reg_read(ST3, 8'h10);
		u_sie_event_model.o_cpu_has_data[1] = 1'b0;
		ev(3, 1);
		reg_read(ST3, 8'h00);
	endtask

	task automatic t_mask();
		reg_write(MK3, 8'h02);
		reg_read(MK3, 8'h02);
		ev(1, 0);
		chk(o_controller_irq, 1'b0);
		reg_read(ST3, 8'h02);
		reg_write(MK3, 8'h00);
		chk(o_controller_irq, 1'b1);
		reg_write(CL3, 8'hFD);
		chk(o_controller_irq, 1'b0);
	endtask

	task automatic t_unsup_alt();
		u_sie_event_model.o_supported[1] = 1'b0;
		ev(1, 1);
		reg_read(ST3, 8'h00);
		chk(o_controller_irq, 1'b0);
		u_sie_event_model.o_supported[1] = 1'b1;
		ev(1, 1);
		reg_read(ST3, 8'h20);
		reg_write(CL3, 8'hDF);
		ev(4, 0);
		chk(o_controller_irq, 1'b1);
		reg_write(ST4, 8'hFF);
		reg_read(ST4, 8'h20);
		reg_write(MK3, 8'hFF);
		reg_write(MK4, 8'hFF);
		reg_read(MK4, 8'h20);
		chk(o_controller_irq, 1'b0);
		reg_write(MK4, 8'h00);
		chk(o_controller_irq, 1'b1);
		reg_write(MK3, 8'h00);
		reg_write(CL4, 8'hDF);
		reg_read(ST4, 8'h00);
	endtask

	task automatic t_hold();
		ev(0, 0);
		u_sie_event_model.o_sie_has_data[0] = 1'b1;
		ev(3, 0);
		reg_read(ST3, 8'h00);
		chk(o_receive_irq_line, 1'b1);
		chk(o_controller_irq, 1'b1);
		u_sie_event_model.o_sie_has_data[0] = 1'b0;
		tick(2);
		chk(o_receive_irq_line, 1'b0);
		chk(o_controller_irq, 1'b0);
	endtask

	task automatic t_mid_reset();
		reg_write(MK3, 8'h01);
		ev(1, 0);
		reg_read(MK3, 8'h01);
		@(posedge i_ref_clk);
		#1;
		i_rst_b = 1'b0;
		tick(2);
		i_rst_b = 1'b1;
		chk(o_rdata, 8'h00);
		t_reset();
	endtask

	initial begin
		{i_rst_b, i_wr, i_rd, i_addr, i_wdata} = '0;
		repeat (3) @(posedge i_ref_clk);
		#1;
		i_rst_b = 1'b1;
		t_reset();
		t_done();
		t_null_nak();
		t_defer();
		t_full();
		t_mask();
		t_unsup_alt();
		t_hold();
		t_mid_reset();
		end_sim();
	end

	initial begin
		#20000;
		fail_count++;
		end_sim();
	end
endmodule // testbench
